// >>> inc/lhi_pkg.sv
// Shared constants and types for the display driver host interface
package lhi_pkg;
	// Bus geometry
	localparam int          LHI_BYTE_W   = 8;
	localparam int          LHI_CNT_W    = 3;
	localparam int          LHI_SI_POS   = 7;
	localparam int          LHI_SCL_POS  = 6;
	// Serial bit counter values
	localparam logic [2:0]  LHI_CNT_RST  = 3'h0;
	localparam logic [2:0]  LHI_CNT_LAST = 3'h7;
	localparam logic [2:0]  LHI_CNT_STEP = 3'h1;
	// Reset values of byte wide state
	localparam logic [7:0]  LHI_BYTE_RST = 8'h00;
	// Output enables, low means driving
	localparam logic [7:0]  LHI_OE_OFF   = 8'hff;
	localparam logic [7:0]  LHI_OE_ON    = 8'h00;
	// Parallel access phase, one bit change away from idle
	typedef enum logic [1:0] {
		LHI_PH_IDLE  = 2'b00,
		LHI_PH_READ  = 2'b01,
		LHI_PH_WRITE = 2'b10
	} lhi_phase_t;
endpackage : lhi_pkg

// >>> rtl/lhi_host_port.sv
// Host port of the bitmap display driver: parallel 68/80 bus and serial link
`timescale 1ns/1ps
// Function
// RL1: Strap high picks parallel, low picks serial
// RL2: Serial port accepts writes only, no readback
// RL3: Serial uses line 7 data, line 6 clock
// RL4: Style strap picks 68 or 80 strobes
// RL5: Select line and direction decode four accesses
// RL6: Serial receiver is shifter plus bit counter
// RL7: Chip select high clears shifter and counter
// RL8: Sample data on clock rise, MSB first
// RL9: Eighth rising edge delivers the byte
// RL10: Select line sampled on each eighth edge
// RL11: Host sends only whole bytes serially
// RL12: Reads return holder, then refetch holder
// RL13: Writes go to holder, then memory
// RL14: Host issues dummy read before real data
// RL15: Host keeps cycle time, inserts no-ops
// RL16: Deselected: bus released, inputs ignored
// RL17: Hardware reset acts whatever chip select
// RL18: 68 transfer lasts while cycle strobe high
module lhi_host_port
	import lhi_pkg::*;
(
	input  wire logic                  core_clk_i,
	input  wire logic                  sys_rst_i,
	input  wire logic                  power_on_clear_n_i,
	input  wire logic                  parallel_select_i,
	input  wire logic                  bus_style_strap_i,
	input  wire logic                  chip_select_n_i,
	input  wire logic                  data_command_select_i,
	input  wire logic                  read_strobe_i,
	input  wire logic                  write_strobe_i,
	input  wire logic [LHI_BYTE_W-1:0] host_bus_lines_i,
	output logic      [LHI_BYTE_W-1:0] host_bus_lines_o,
	output logic      [LHI_BYTE_W-1:0] host_bus_lines_oe_n_o,
	input  wire logic [LHI_BYTE_W-1:0] status_word_i,
	input  wire logic [LHI_BYTE_W-1:0] mem_rd_data_i,
	output logic                       mem_rd_req_o,
	output logic                       mem_wr_req_o,
	output logic      [LHI_BYTE_W-1:0] mem_wr_data_o,
	output logic                       instr_valid_o,
	output logic      [LHI_BYTE_W-1:0] instr_byte_o
);

	// Strobe decode per bus style, returns {read active, write active}
	// 68 style: E qualifies, R/W picks the direction while E is high
	// 80 style: each direction has its own active-low strobe pin
	// Both 80 pins low at once counts as no access at all
	function automatic logic [1:0] lhi_strobe_decode(
		input logic style68,
		input logic rd_pin,
		input logic wr_pin
	);
		logic [1:0] act;
		act = 2'b00;
		if (style68) begin
			act = {rd_pin & wr_pin, rd_pin & ~wr_pin}; // [RL4] [RL18]
		end else begin
			act = {~rd_pin & wr_pin, rd_pin & ~wr_pin}; // [RL4]
		end
		return act;
	endfunction : lhi_strobe_decode

	// Output pulses are suppressed in the cycle after any cycle the pin reset is low
	function automatic logic lhi_gate_pulse(
		input logic clr,
		input logic ev
	);
		return ~clr & ev;
	endfunction : lhi_gate_pulse

	lhi_phase_t                phase;
	logic                      hw_clear;
	logic                      selected;
	logic                      par_sel;
	logic                      ser_sel;
	logic [1:0]                strobe_act;
	logic                      rd_act;
	logic                      wr_act;
	logic                      rd_start;
	logic [LHI_BYTE_W-1:0]     cap_byte;
	logic                      cap_a0;
	logic                      rd_a0;
	logic [LHI_BYTE_W-1:0]     rd_out;
	logic                      par_wr_done;
	logic                      par_rd_done;
	logic                      scl_prev;
	logic                      scl_rise;
	logic [LHI_BYTE_W-1:0]     shifter;
	logic [LHI_CNT_W-1:0]      bit_cnt;
	logic                      ser_done;
	logic [LHI_BYTE_W-1:0]     ser_byte;
	logic                      data_wr;
	logic                      instr_wr;
	logic [LHI_BYTE_W-1:0]     new_byte;
	logic [LHI_BYTE_W-1:0]     holder;

	// Port selection; the pin reset clears state in any chip select state
	// The straps are static; moving one in mid-access is not supported
	assign hw_clear = ~power_on_clear_n_i; // [RL17]
	assign selected = ~chip_select_n_i; // [RL16]
	assign par_sel  = parallel_select_i & selected; // [RL1]
	assign ser_sel  = ~parallel_select_i & selected; // [RL1]

	// Strobes count only in parallel mode, serial ignores them
	// In serial mode the strobe pins are unused and may float, so gate them
	assign strobe_act = lhi_strobe_decode(bus_style_strap_i, read_strobe_i, write_strobe_i);
	assign rd_act     = par_sel & strobe_act[1]; // [RL3] [RL16]
	assign wr_act     = par_sel & strobe_act[0]; // [RL3] [RL16]

	// Start of a read, and ends of parallel accesses on the strobe trailing edge
	// A chip select rise in mid-strobe abandons the access, it never ends
	// An access ends in the first cycle its strobe is seen inactive
	assign rd_start    = (phase == LHI_PH_IDLE) & rd_act;
	assign par_wr_done = (phase == LHI_PH_WRITE) & ~wr_act & par_sel;
	assign par_rd_done = (phase == LHI_PH_READ) & ~rd_act & par_sel;

	// Parallel access phase tracker
	// Each access passes through idle, so back to back strobes stay apart
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			phase <= LHI_PH_IDLE;
		end else if (hw_clear || !par_sel) begin
			phase <= LHI_PH_IDLE; // [RL16] [RL17]
		end else begin
			case (phase)
				LHI_PH_IDLE: begin
					if (rd_act) begin
						phase <= LHI_PH_READ;
					end else if (wr_act) begin
						phase <= LHI_PH_WRITE;
					end
				end
				LHI_PH_READ: begin
					if (!rd_act) begin
						phase <= LHI_PH_IDLE;
					end
				end
				LHI_PH_WRITE: begin
					if (!wr_act) begin
						phase <= LHI_PH_IDLE;
					end
				end
				default: begin
					phase <= LHI_PH_IDLE;
				end
			endcase
		end
	end

	// Write byte follows the bus while the write strobe is active
	// The last active cycle wins, so a slow bus may settle late in the strobe
	// Not cleared by the pin reset: it is read only in the cycle a write ends
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cap_byte <= LHI_BYTE_RST;
		end else if (wr_act) begin
			cap_byte <= host_bus_lines_i; // [RL18]
		end
	end

	// Select level of the write, held steady for the whole strobe by the host
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cap_a0 <= 1'b0;
		end else if (wr_act) begin
			cap_a0 <= data_command_select_i; // [RL5] [RL18]
		end
	end

	// Read data chosen at the read strobe leading edge
	// Status is a snapshot taken as the strobe starts, held for the whole read
	// Display data comes from the holder, so a read after a move is stale
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rd_out <= LHI_BYTE_RST;
		end else if (hw_clear) begin
			rd_out <= LHI_BYTE_RST;
		end else if (rd_start) begin
			rd_out <= data_command_select_i ? holder : status_word_i; // [RL5] [RL12]
		end
	end

	// Marks a display data read, so that its end fetches the next word
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rd_a0 <= 1'b0;
		end else if (hw_clear) begin
			rd_a0 <= 1'b0;
		end else if (rd_start) begin
			rd_a0 <= data_command_select_i; // [RL12]
		end
	end

	// Bus is driven only during a selected parallel read
	// The enable drops at once when the strobe or chip select leaves, which
	// turns the bus around before the host can drive it again
	assign host_bus_lines_o      = rd_out;
	assign host_bus_lines_oe_n_o = (phase == LHI_PH_READ && rd_act) ?
		LHI_OE_ON : LHI_OE_OFF; // [RL2] [RL3] [RL16]

	// Shift clock history for rising edge detection
	// It runs in every mode, so a clock already high at select is not a rise
	// Its reset level is the parked low level of the shift clock
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			scl_prev <= 1'b0;
		end else begin
			scl_prev <= host_bus_lines_i[LHI_SCL_POS];
		end
	end

	// Serial edge, byte with the new bit, and the eighth edge marker
	// Gated by the serial select, so a deselected clock toggles nothing
	assign scl_rise = ser_sel & host_bus_lines_i[LHI_SCL_POS] & ~scl_prev; // [RL3] [RL8]
	assign ser_byte = {shifter[LHI_BYTE_W-2:0], host_bus_lines_i[LHI_SI_POS]}; // [RL8]
	assign ser_done = scl_rise & (bit_cnt == LHI_CNT_LAST); // [RL9]

	// Serial shifter and bit counter, cleared while deselected
	// A partial byte cut by deselect or the pin reset is dropped, never sent
	// The counter wraps from seven to zero, so bytes may follow back to back
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			shifter <= LHI_BYTE_RST;
			bit_cnt <= LHI_CNT_RST;
		end else if (hw_clear || !ser_sel) begin
			shifter <= LHI_BYTE_RST; // [RL7] [RL17]
			bit_cnt <= LHI_CNT_RST; // [RL7]
		end else if (scl_rise) begin
			shifter <= ser_byte; // [RL6] [RL8]
			bit_cnt <= bit_cnt + LHI_CNT_STEP; // [RL6] [RL9]
		end
	end

	// Byte dispatch shared by both ports; serial samples select on the eighth edge
	// The two ports are never selected together, so the branches cannot meet
	always_comb begin
		data_wr  = 1'b0;
		instr_wr = 1'b0;
		new_byte = ser_byte; // [RL9]
		if (par_wr_done) begin
			data_wr  = cap_a0; // [RL5]
			instr_wr = ~cap_a0; // [RL5]
			new_byte = cap_byte;
		end else if (ser_done) begin
			data_wr  = data_command_select_i; // [RL10]
			instr_wr = ~data_command_select_i; // [RL10]
		end
	end

	// Memory fetch requested when a display data read completes
	// Fetching at the end of the read is what makes the next read current
	// A status read leaves the holder and display memory untouched
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			mem_rd_req_o <= 1'b0;
		end else begin
			mem_rd_req_o <= lhi_gate_pulse(hw_clear, par_rd_done & rd_a0); // [RL12]
		end
	end

	// Bus holder: written bytes, or the word fetched after a read
	// A write in the same cycle as a fetch return keeps the written byte
	// A read after a write returns the written byte once, hence the dummy read
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			holder <= LHI_BYTE_RST;
		end else if (hw_clear) begin
			holder <= LHI_BYTE_RST;
		end else if (data_wr) begin
			holder <= new_byte; // [RL13]
		end else if (mem_rd_req_o) begin
			holder <= mem_rd_data_i; // [RL12]
		end
	end

	// Commit of the holder into display memory one cycle after capture
	// The request meets the holder already loaded, so data and strobe align
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			mem_wr_req_o <= 1'b0;
		end else begin
			mem_wr_req_o <= lhi_gate_pulse(hw_clear, data_wr); // [RL13]
		end
	end

	// Display memory sees the holder directly, steady until the next capture
	assign mem_wr_data_o = holder; // [RL13]

	// Instruction pulse handed to the decoder, one cycle per byte
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			instr_valid_o <= 1'b0;
		end else begin
			instr_valid_o <= lhi_gate_pulse(hw_clear, instr_wr); // [RL5] [RL9]
		end
	end

	// Instruction byte, held after the pulse so a slow decoder may take it late
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			instr_byte_o <= LHI_BYTE_RST;
		end else if (instr_wr) begin
			instr_byte_o <= new_byte; // [RL9]
		end
	end

endmodule : lhi_host_port

// >>> testbench/lhi_host_port_properties.sv
// Checker of the host port pin timing
`timescale 1ns/1ps
module lhi_port_chk
	import lhi_pkg::*;
(
	input wire logic       core_clk_i,
	input wire logic       sys_rst_i,
	input wire logic       power_on_clear_n_i,
	input wire logic       parallel_select_i,
	input wire logic       bus_style_strap_i,
	input wire logic       chip_select_n_i,
	input wire logic       data_command_select_i,
	input wire logic       read_strobe_i,
	input wire logic       write_strobe_i,
	input wire logic [7:0] host_bus_lines_i,
	input wire logic [7:0] host_bus_lines_oe_n_o,
	input wire logic       mem_rd_req_o,
	input wire logic       mem_wr_req_o,
	input wire logic       instr_valid_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (sys_rst_i);
	wire pulses = mem_rd_req_o | mem_wr_req_o | instr_valid_o;
	wire ser = !parallel_select_i;
	// Bus release, quiet deselect, serial write only
	property p_cs_off; chip_select_n_i |-> host_bus_lines_oe_n_o == LHI_OE_OFF; endproperty
	a_cs_off: assert property (p_cs_off) else $error("bus driven while deselected");
	property p_cs_quiet; chip_select_n_i [*2] |=> !pulses; endproperty
	a_cs_quiet: assert property (p_cs_quiet) else $error("pulse while deselected");
	property p_ser_ro; ser |-> host_bus_lines_oe_n_o == LHI_OE_OFF && !mem_rd_req_o; endproperty
	a_ser_ro: assert property (p_ser_ro) else $error("readback in serial mode");
	// Driving only during a read strobe of the chosen style
	property p_drive;
		host_bus_lines_oe_n_o != LHI_OE_OFF |-> (bus_style_strap_i ?
			read_strobe_i && write_strobe_i : !read_strobe_i && write_strobe_i);
	endproperty
	a_drive: assert property (p_drive) else $error("drive without read strobe");
	// Serial byte completes right after a shift clock rise
	property p_ser_rise;
		ser && instr_valid_o |-> $past(host_bus_lines_i[6]) && !$past(host_bus_lines_i[6], 2);
	endproperty
	a_ser_rise: assert property (p_ser_rise) else $error("byte not on clock rise");
	property p_ser_dc;
		ser && pulses |-> $past(data_command_select_i) == mem_wr_req_o;
	endproperty
	a_ser_dc: assert property (p_ser_dc) else $error("serial routing wrong");
	property p_poc; !power_on_clear_n_i |=> !pulses; endproperty
	a_poc: assert property (p_poc) else $error("pulse during hardware reset");
	property p_one; mem_wr_req_o |=> !mem_wr_req_o; endproperty
	a_one: assert property (p_one) else $error("commit longer than a cycle");
	c_ser: cover property (ser && instr_valid_o);
	c_rd: cover property (mem_rd_req_o);
	c_wr: cover property (parallel_select_i && mem_wr_req_o);
endmodule : lhi_port_chk

// >>> testbench/lhi_mpu_model.sv
// Microprocessor model driving the host port pins
`timescale 1ns/1ps
module lhi_mpu_model (
	input  wire logic       clk_i,
	input  wire logic       style_i,
	input  wire logic [7:0] rd_data_i,
	output logic            cs_n_o,
	output logic            dcs_o,
	output logic            rd_o,
	output logic            wr_o,
	output logic [7:0]      bus_o
);
	logic act = 1'b0;
	logic dir = 1'b1;
	// Strobe pins from access state, idle levels per style
	assign rd_o = style_i ? act : !(act && dir);
	assign wr_o = style_i ? dir : !(act && !dir);
	initial {cs_n_o, dcs_o, bus_o} = 10'h200;
	task automatic sel(input logic c);
		@(posedge clk_i);
		cs_n_o <= !c;
		@(posedge clk_i);
	endtask : sel
	// One parallel access, direction steady over the strobe
	task automatic par(input logic c, r, a, input logic [7:0] d, output logic [7:0] q);
		@(posedge clk_i);
		cs_n_o <= !c;
		dcs_o  <= a;
		bus_o  <= r ? ~bus_o : d;
		dir    <= r;
		act    <= 1'b1;
		repeat (2) @(posedge clk_i);
		q = rd_data_i;
		act <= 1'b0;
		dir <= 1'b1;
		repeat (3) @(posedge clk_i);
	endtask : par
	// Serial bits, MSB first, clock parked low after
	task automatic ser(input logic a, input logic [7:0] d, input int n);
		for (int i = 7; i > 7 - n; i--) begin
			@(posedge clk_i);
			bus_o[7] <= d[i];
			bus_o[6] <= 1'b0;
			dcs_o    <= a;
			@(posedge clk_i);
			bus_o[6] <= 1'b1;
		end
		@(posedge clk_i);
		bus_o <= {~bus_o[7], 1'b0, bus_o[5:0]};
		repeat (3) @(posedge clk_i);
	endtask : ser
endmodule : lhi_mpu_model

// >>> testbench/tb_lhi_host_port.sv
// Self-checking bench of the host port
`timescale 1ns/1ps
`define CHK(n, e, g) begin \
	samples_checked++; \
	if ((g) !== (e)) begin \
		errors++; \
		$display("BAD %s exp %h got %h", n, e, g); \
	end \
end
module tb_lhi_host_port;
	logic        clk, rst, poc_n, par_sel, style, cs_n, dcs, rd, wr, rdq, wrq, iv;
	logic [7:0]  bus, wbus, bus_o, oe_n, stat, mrd, wdat, ibyte, lw, q, d, m, s;
	logic [31:0] seed = 32'hd796;
	int          errors, samples_checked, n_ins, n_wr, n_rd, k;
	// Shared wire: design wins where it enables
	assign wbus = (bus_o & ~oe_n) | (bus & oe_n);
	lhi_host_port DUT (.core_clk_i(clk), .sys_rst_i(rst), .power_on_clear_n_i(poc_n),
		.parallel_select_i(par_sel), .bus_style_strap_i(style), .chip_select_n_i(cs_n),
		.data_command_select_i(dcs), .read_strobe_i(rd), .write_strobe_i(wr),
		.host_bus_lines_i(wbus), .host_bus_lines_o(bus_o), .host_bus_lines_oe_n_o(oe_n),
		.status_word_i(stat), .mem_rd_data_i(mrd), .mem_rd_req_o(rdq), .mem_wr_req_o(wrq),
		.mem_wr_data_o(wdat), .instr_valid_o(iv), .instr_byte_o(ibyte));
	lhi_mpu_model mpu (.clk_i(clk), .style_i(style), .rd_data_i(wbus), .cs_n_o(cs_n),
		.dcs_o(dcs), .rd_o(rd), .wr_o(wr), .bus_o(bus));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// Pulse counters and last committed byte
	always @(posedge clk) begin
		n_ins += int'(iv);
		n_wr += int'(wrq);
		n_rd += int'(rdq);
		if (wrq === 1'b1)
			lw <= wdat;
	end
	function automatic logic [7:0] rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed[7:0];
	endfunction : rnd
	task automatic ser_chk(input logic a, input logic [7:0] v);
		k = a ? n_wr : n_ins;
		mpu.ser(a, v, 8);
		`CHK("serial count", k + 1, a ? n_wr : n_ins)
		`CHK("serial byte", v, a ? lw : ibyte)
	endtask : ser_chk
	task automatic end_of_test();
		$display("errors %0d samples_checked %0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_of_test
	initial begin
		{rst, poc_n, par_sel, style, stat, mrd} = 20'hc_0000;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		mpu.sel(1'b1);
		ser_chk(1'b0, 8'hff);
		ser_chk(1'b1, 8'h00);
		repeat (6) ser_chk(rnd() > 8'h7f, rnd());
		// Partial byte cut by deselect, then by hardware reset
		for (int i = 0; i < 2; i++) begin
			k = n_ins;
			mpu.ser(1'b0, 8'ha5, 3);
			poc_n <= !i[0];
			mpu.sel(i[0]);
			poc_n <= 1'b1;
			mpu.sel(1'b1);
			mpu.ser(1'b0, 8'h3c, 8);
			`CHK("partial drop", k + 1, n_ins)
			`CHK("byte after drop", 8'h3c, ibyte)
		end
		// Strobes in serial mode: no access, no drive, partial bits dropped
		k = n_rd + n_wr + n_ins;
		mpu.par(1'b1, 1'b1, 1'b1, 8'h00, q);
		mpu.par(1'b1, 1'b0, 1'b1, 8'h00, q);
		`CHK("serial strobes", k, n_rd + n_wr + n_ins)
		mpu.sel(1'b0);
		par_sel <= 1'b1;
		// Both bus styles: instruction, commit, dummy read, status, deselect
		for (int i = 0; i < 2; i++) begin
			style <= i[0];
			d = rnd();
			m = rnd();
			s = rnd();
			mpu.par(1'b1, 1'b0, 1'b0, d, q);
			`CHK("instr", d, ibyte)
			mpu.par(1'b1, 1'b0, 1'b1, ~d, q);
			`CHK("commit", ~d, lw)
			mrd <= m;
			stat <= s;
			mpu.par(1'b1, 1'b1, 1'b1, 8'h00, q);
			`CHK("dummy read", ~d, q)
			mpu.par(1'b1, 1'b1, 1'b1, 8'h00, q);
			`CHK("data read", m, q)
			k = n_rd;
			mpu.par(1'b1, 1'b1, 1'b0, 8'h00, q);
			`CHK("status", s, q)
			`CHK("status fetch", k, n_rd)
			k = n_wr;
			mpu.par(1'b0, 1'b0, 1'b1, d, q);
			`CHK("deselected write", k, n_wr)
		end
		end_of_test();
	end
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		end_of_test();
	end
endmodule : tb_lhi_host_port
bind lhi_host_port lhi_port_chk chk (.core_clk_i, .sys_rst_i, .power_on_clear_n_i,
	.parallel_select_i, .bus_style_strap_i, .chip_select_n_i, .data_command_select_i,
	.read_strobe_i, .write_strobe_i, .host_bus_lines_i, .host_bus_lines_oe_n_o,
	.mem_rd_req_o, .mem_wr_req_o, .instr_valid_o);
